// >>> msb_pkg.sv
// shared constants, states and carrier types of the muting safety bridge
package msb_pkg;
  // ==========================================================================
  // clock and timer bases
  localparam int          CLK_HZ         = 100_000_000;
  localparam int          TICK_MS        = 10;                     // one hundredth of a second
  localparam int          TICK_CYCLES    = CLK_HZ / 1000 * TICK_MS; // 10 ms in clock cycles
  localparam int          MIN_TICK_DIV   = 60;                     // 0.01 min = 60 x 0.01 s
  localparam logic [15:0] MON_MAX        = 16'hea60;               // 600.00 min in 0.01 min
  localparam logic [15:0] DROP_MAX       = 16'h1770;               // 60.00 s in 0.01 s
  localparam logic [15:0] OVR_MAX        = 16'h4650;               // 180.00 s in 0.01 s
  // ==========================================================================
  // register map (byte addresses)
  localparam logic [7:0]  ADR_CTRL       = 8'h00;
  localparam logic [7:0]  ADR_MON        = 8'h04;
  localparam logic [7:0]  ADR_DROP       = 8'h08;
  localparam logic [7:0]  ADR_OVR        = 8'h0c;
  localparam logic [7:0]  ADR_STATUS     = 8'h10;
  localparam int          CTRL_AUTO_BIT  = 0;
  localparam logic        CTRL_RESET     = 1'h0;
  localparam logic [15:0] PRESET_RESET   = 16'h0000;
  // ==========================================================================
  // states and carriers
  typedef enum logic [1:0] {
    ST_STOP = 2'b00,
    ST_RUN  = 2'b01,
    ST_MUTE = 2'b10,
    ST_OVR  = 2'b11
  } msb_state_type;

  typedef struct packed {
    logic note_override_only;
    logic note_muting_active;
    logic note_timeout_end;
    logic note_no_new_mute;
    logic note_override_ended;
    logic note_motion_seen;
    logic note_mute_paused;
    logic note_single_sensor;
    logic note_barrier_fault;
  } msb_note_type;

  typedef struct packed {
    logic monitor_timer_running;
    logic dropout_timer_running;
    logic override_timer_running;
  } msb_timer_type;
endpackage

// >>> msb_sync.sv
// two-flop synchroniser for pin inputs
`timescale 1ns/1ps
`default_nettype none
module msb_sync
  import msb_pkg::*;
#(
  parameter int W = 1
) (
  input  wire logic         clk,
  input  wire logic         rst_b,
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);
  logic [W-1:0] meta_reg;
  logic [W-1:0] q_reg;
  // ==========================================================================
  // the first stage feeds only the second
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      meta_reg <= '0;
      q_reg    <= '0;
    end else begin
      meta_reg <= d;
      q_reg    <= meta_reg;
    end
  end
  assign q = q_reg;
endmodule
`default_nettype wire

// >>> msb_timer.sv
// preset timer counting ticks while run, held while paused
`timescale 1ns/1ps
`default_nettype none
module msb_timer
  import msb_pkg::*;
#(
  parameter int CW = 16
) (
  input  wire logic          clk,
  input  wire logic          rst_b,
  input  wire logic          run,
  input  wire logic          pause,
  input  wire logic          tick,
  input  wire logic [CW-1:0] preset,
  output logic               expired,
  output logic [CW-1:0]      count
);
  logic [CW-1:0] count_reg;
  logic [CW-1:0] count_next;
  // ==========================================================================
  // count restarts from zero whenever run drops
  always_comb begin
    count_next = '0;
    if (run) begin
      count_next = count_reg;
      if (tick && !pause && count_reg < preset) begin
        count_next = count_reg + 1'b1;
      end
    end
  end
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      count_reg <= '0;
    end else begin
      count_reg <= count_next;
    end
  end
  assign expired = run && (count_reg >= preset);
  assign count   = count_reg;

  AST_PAUSE_HOLD: assert property (@(posedge clk) disable iff (!rst_b)
    run && pause && $past(run) |=> $stable(count_reg) || !run)
    else $error("timer advanced while paused");
endmodule
`default_nettype wire

// >>> msb_bridge.sv
// muting safety bridge: state machine, timers, notes and register slave
//
// Added by the designer: the register addresses and the Wishbone interface to the registers.
`timescale 1ns/1ps
`default_nettype none
module msb_bridge
  import msb_pkg::*;
#(
  parameter int TICK_COUNT = TICK_CYCLES
) (
  input  wire logic    clk,
  input  wire logic    rst_b,
  input  wire logic    wb_cyc_i,
  input  wire logic    wb_stb_i,
  input  wire logic    wb_we_i,
  input  wire logic [7:0] wb_adr_i,
  input  wire logic [3:0] wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic [31:0]  wb_dat_o,
  output logic         wb_ack_o,
  input  wire logic    barrier_chan_a,
  input  wire logic    barrier_chan_b,
  input  wire logic    mute_sensor_front_first,
  input  wire logic    mute_sensor_front_second,
  input  wire logic    mute_sensor_rear_first,
  input  wire logic    mute_sensor_rear_second,
  input  wire logic    pause_mute_timer_in,
  input  wire logic    override_button_in,
  input  wire logic    end_on_free_field_mode,
  input  wire logic    override_style_select,
  input  wire logic    start_button_in,
  output logic         mute_lamp_out,
  output logic         safety_enable_out,
  output logic         override_active_out,
  output logic         single_channel_fault,
  output msb_note_type notes,
  output msb_timer_type timers
);
  // ==========================================================================
  // input synchronisers
  logic [10:0] pins_s;
  msb_sync #(.W(11)) u_sync (
    .clk   (clk),
    .rst_b (rst_b),
    .d     ({barrier_chan_a, barrier_chan_b, mute_sensor_front_first, mute_sensor_front_second,
             mute_sensor_rear_first, mute_sensor_rear_second, pause_mute_timer_in,
             override_button_in, end_on_free_field_mode, override_style_select, start_button_in}),
    .q     (pins_s)
  );
  logic       ch_a, ch_b, pause_s, ovr_s, end_mode, style, start_s;
  logic [3:0] sens;
  assign {ch_a, ch_b, sens, pause_s, ovr_s, end_mode, style, start_s} = pins_s;

  // ==========================================================================
  // wishbone register slave
  logic        auto_reg, auto_next;
  logic [15:0] mon_reg, mon_next, drop_reg, drop_next, ovr_reg, ovr_next;
  logic        ack_reg, ack_next;
  logic [31:0] dat_reg, dat_next;
  logic [31:0] status_word;
  logic        wr_go;

  // byte-lane merge used by every preset register
  function automatic logic [15:0] lane_merge(input logic [15:0] old, input logic [31:0] dat,
                                             input logic [3:0] sel, input logic [15:0] lim);
    logic [15:0] m;
    m = old;
    if (sel[0]) m[7:0] = dat[7:0];
    if (sel[1]) m[15:8] = dat[15:8];
    lane_merge = (m > lim) ? lim : m;
  endfunction

  // ack one cycle after the strobe, dropped the cycle after; a write lands at the ack edge
  always_comb begin
    wr_go     = wb_cyc_i && wb_stb_i && wb_we_i && ack_reg;
    ack_next  = wb_cyc_i && wb_stb_i && !ack_reg;
    auto_next = auto_reg;
    mon_next  = mon_reg;
    drop_next = drop_reg;
    ovr_next  = ovr_reg;
    dat_next  = 32'h0000_0000;
    if (wr_go) begin
      case (wb_adr_i)
        ADR_CTRL: if (wb_sel_i[0]) auto_next = wb_dat_i[CTRL_AUTO_BIT];
        ADR_MON:  mon_next = lane_merge(mon_reg, wb_dat_i, wb_sel_i, MON_MAX);
        ADR_DROP: drop_next = lane_merge(drop_reg, wb_dat_i, wb_sel_i, DROP_MAX);
        ADR_OVR:  ovr_next = lane_merge(ovr_reg, wb_dat_i, wb_sel_i, OVR_MAX);
        default:  auto_next = auto_reg; // unmapped writes are acked and dropped
      endcase
    end
    if (ack_next && !wb_we_i) begin
      case (wb_adr_i)
        ADR_CTRL:   dat_next = {31'h0, auto_reg};
        ADR_MON:    dat_next = {16'h0000, mon_reg};
        ADR_DROP:   dat_next = {16'h0000, drop_reg};
        ADR_OVR:    dat_next = {16'h0000, ovr_reg};
        ADR_STATUS: dat_next = status_word;
        default:    dat_next = 32'h0000_0000;
      endcase
    end
  end
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      auto_reg <= CTRL_RESET;
      mon_reg  <= PRESET_RESET;
      drop_reg <= PRESET_RESET;
      ovr_reg  <= PRESET_RESET;
      ack_reg  <= 1'b0;
      dat_reg  <= 32'h0000_0000;
    end else begin
      auto_reg <= auto_next;
      mon_reg  <= mon_next;
      drop_reg <= drop_next;
      ovr_reg  <= ovr_next;
      ack_reg  <= ack_next;
      dat_reg  <= dat_next;
    end
  end
  assign wb_ack_o = ack_reg;
  assign wb_dat_o = dat_reg;

  // ==========================================================================
  // time base: 10 ms tick and 0.01 min tick
  logic [31:0] pre_reg, pre_next;
  logic [7:0]  min_reg, min_next;
  logic        tick_cs, tick_cm;
  always_comb begin
    tick_cs  = (pre_reg == 32'(TICK_COUNT - 1));
    pre_next = tick_cs ? 32'h0000_0000 : pre_reg + 32'h0000_0001;
    tick_cm  = tick_cs && (min_reg == 8'(MIN_TICK_DIV - 1));
    min_next = tick_cm ? 8'h00 : (tick_cs ? min_reg + 8'h01 : min_reg);
  end
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      pre_reg <= 32'h0000_0000;
      min_reg <= 8'h00;
    end else begin
      pre_reg <= pre_next;
      min_reg <= min_next;
    end
  end

  // ==========================================================================
  // timers
  msb_state_type state_reg, state_next;
  logic [3:0]    sens_prev_reg;
  logic          sens_change, pause_eff;
  logic          mon_exp, drop_exp, ovr_exp, field_free;
  logic [15:0]   mon_cnt;
  // a sensor change lifts the pause of the monitoring time for that cycle
  assign sens_change = (sens != sens_prev_reg);
  assign pause_eff   = pause_s && !sens_change;
  assign field_free  = ch_a && ch_b;

  msb_timer #(.CW(16)) u_mon (
    .clk (clk), .rst_b (rst_b), .run (state_reg == ST_MUTE), .pause (pause_eff),
    .tick (tick_cm), .preset (mon_reg), .expired (mon_exp), .count (mon_cnt)
  );
  msb_timer #(.CW(16)) u_drop (
    .clk (clk), .rst_b (rst_b), .run (state_reg == ST_RUN && !field_free), .pause (1'b0),
    .tick (tick_cs), .preset (drop_reg), .expired (drop_exp), .count ()
  );
  msb_timer #(.CW(16)) u_ovr (
    .clk (clk), .rst_b (rst_b), .run (state_reg == ST_OVR), .pause (1'b0),
    .tick (tick_cs), .preset (ovr_reg), .expired (ovr_exp), .count ()
  );

  // ==========================================================================
  // muting state machine
  logic start_prev_reg, ovr_prev_reg, seen_block_reg, seen_block_next;
  logic any_sensor, pair_ok, start_ok, ovr_trig, mute_end, free_end, to_end;
  msb_note_type notes_reg, notes_next;
  msb_timer_type timers_reg, timers_next;
  logic lamp_reg, enable_reg, ovr_ind_reg, fault_reg;

  always_comb begin
    any_sensor = |sens;
    // adjacent pairs A1+A2, A2+B1, B1+B2 may carry a muting
    pair_ok    = (sens[3] && sens[2]) || (sens[2] && sens[1]) || (sens[1] && sens[0]);
    start_ok   = auto_reg || (start_prev_reg && !start_s);
    ovr_trig   = style ? ovr_s : (ovr_s && !ovr_prev_reg);
    free_end   = end_mode && field_free && seen_block_reg;
    to_end     = mon_exp || free_end;
    mute_end   = to_end || !pair_ok;
    state_next = state_reg;
    case (state_reg)
      ST_STOP: begin
        if (field_free && start_ok) begin
          state_next = ST_RUN;
        end else if (!auto_reg && pair_ok && ovr_trig) begin
          state_next = ST_OVR;
        end
      end
      ST_RUN: begin
        if (pair_ok && !notes_reg.note_no_new_mute) begin
          state_next = ST_MUTE;
        end else if (!field_free && drop_exp) begin
          state_next = ST_STOP;
        end
      end
      ST_MUTE: begin
        if (mute_end) begin
          state_next = field_free ? ST_RUN : ST_STOP;
        end
      end
      ST_OVR: begin
        if (ovr_exp || (style && !ovr_s)) begin
          state_next = ST_STOP;
        end else if (field_free) begin
          state_next = ST_RUN;
        end
      end
      default: state_next = ST_STOP;
    endcase
    seen_block_next = (state_next == ST_MUTE) && (seen_block_reg || !field_free);
  end

  // notes: levels, each set wins over its clear
  always_comb begin
    notes_next = notes_reg;
    notes_next.note_override_only = any_sensor && (state_next == ST_STOP);
    notes_next.note_muting_active = (state_next == ST_MUTE);
    if (state_reg == ST_MUTE && to_end) notes_next.note_timeout_end = 1'b1;
    else if (state_next == ST_MUTE) notes_next.note_timeout_end = 1'b0;
    if (state_reg == ST_MUTE && mute_end && any_sensor) notes_next.note_no_new_mute = 1'b1;
    else if (!any_sensor) notes_next.note_no_new_mute = 1'b0;
    if (state_reg == ST_OVR && state_next != ST_OVR) notes_next.note_override_ended = 1'b1;
    else if (state_next == ST_OVR) notes_next.note_override_ended = 1'b0;
    if (state_reg == ST_MUTE && pause_s && sens_change) notes_next.note_motion_seen = 1'b1;
    else if (!pause_s) notes_next.note_motion_seen = 1'b0;
    if (pause_s && state_reg != ST_MUTE) notes_next.note_mute_paused = 1'b1;
    else if (!pause_s) notes_next.note_mute_paused = 1'b0;
    notes_next.note_single_sensor = any_sensor;
    notes_next.note_barrier_fault = ch_a ^ ch_b;
    timers_next.monitor_timer_running  = (state_next == ST_MUTE);
    timers_next.dropout_timer_running  = (state_next == ST_RUN) && !field_free;
    timers_next.override_timer_running = (state_next == ST_OVR);
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      state_reg      <= ST_STOP;
      sens_prev_reg  <= 4'h0;
      start_prev_reg <= 1'b0;
      ovr_prev_reg   <= 1'b0;
      seen_block_reg <= 1'b0;
      notes_reg      <= '0;
      timers_reg     <= '0;
      lamp_reg       <= 1'b0;
      enable_reg     <= 1'b0;
      ovr_ind_reg    <= 1'b0;
      fault_reg      <= 1'b0;
    end else begin
      state_reg      <= state_next;
      sens_prev_reg  <= sens;
      start_prev_reg <= start_s;
      ovr_prev_reg   <= ovr_s;
      seen_block_reg <= seen_block_next;
      notes_reg      <= notes_next;
      timers_reg     <= timers_next;
      lamp_reg       <= (state_next == ST_MUTE);
      enable_reg     <= (state_next != ST_STOP);
      ovr_ind_reg    <= (state_next == ST_OVR);
      fault_reg      <= ch_a ^ ch_b;
    end
  end
  assign mute_lamp_out        = lamp_reg;
  assign safety_enable_out    = enable_reg;
  assign override_active_out  = ovr_ind_reg;
  assign single_channel_fault = fault_reg;
  assign notes                = notes_reg;
  assign timers               = timers_reg;
  assign status_word = {16'h0000, 1'b0, timers_reg, fault_reg, state_reg, notes_reg};

  // ==========================================================================
  // checks
  sequence start_fall_s;
    start_prev_reg && !start_s;
  endsequence
  sequence stop_ready_s;
    state_reg == ST_STOP && field_free && !auto_reg;
  endsequence

  AST_FAULT: assert property (@(posedge clk) disable iff (!rst_b)
    (ch_a != ch_b) |=> single_channel_fault) else $error("fault flag missed");
  AST_LAMP: assert property (@(posedge clk) disable iff (!rst_b)
    mute_lamp_out == (state_reg == ST_MUTE)) else $error("lamp mismatch");
  AST_OVR_IND: assert property (@(posedge clk) disable iff (!rst_b)
    override_active_out == (state_reg == ST_OVR) && (!override_active_out || safety_enable_out))
    else $error("override indicator mismatch");
  AST_FREE_END: assert property (@(posedge clk) disable iff (!rst_b)
    state_reg == ST_MUTE && end_mode && field_free && seen_block_reg |=> !mute_lamp_out ##1
    notes.note_timeout_end) else $error("free field did not end muting");
  AST_EDGE_OVR: assert property (@(posedge clk) disable iff (!rst_b)
    state_reg == ST_STOP && !field_free && !auto_reg && !style && pair_ok && ovr_s && !ovr_prev_reg
    |=> override_active_out && safety_enable_out) else $error("edge override missed");
  AST_HOLD: assert property (@(posedge clk) disable iff (!rst_b)
    state_reg == ST_OVR && style && !ovr_s |=> !override_active_out)
    else $error("held override outlived button");
  AST_START: assert property (@(posedge clk) disable iff (!rst_b)
    stop_ready_s and start_fall_s |=> safety_enable_out) else $error("start edge ignored");
  AST_TIMEOUT: assert property (@(posedge clk) disable iff (!rst_b)
    state_reg == ST_MUTE && mon_exp |=> !mute_lamp_out && notes.note_timeout_end)
    else $error("timeout did not end muting");
  AST_RESET: assert property (@(posedge clk)
    $rose(rst_b) |-> !safety_enable_out && !mute_lamp_out && !override_active_out && timers == '0)
    else $error("outputs not cleared by reset");
endmodule
`default_nettype wire

// >>> msb_field_model.sv
// far-side model: light barrier, four muting sensors and a travelling pallet
`timescale 1ns/1ps
`default_nettype none
module msb_field_model
  import msb_pkg::*;
#(
  parameter int STEP = 20
) (
  input  wire logic       clk,
  input  wire logic       rst_b,
  input  wire logic       go,
  input  wire logic       hold,
  input  wire logic       chan_fault,
  output logic            chan_a,
  output logic            chan_b,
  output logic [3:0]      sens
);
  // ==========================================================================
  // pallet position, one step every STEP cycles; hold models a jam
  logic [3:0] pos_reg;
  logic [7:0] cnt_reg;
  logic       blocked;

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      pos_reg <= 4'h0;
      cnt_reg <= 8'h00;
    end else if (pos_reg == 4'h0) begin
      pos_reg <= {3'h0, go};
      cnt_reg <= 8'h00;
    end else if (!hold) begin
      cnt_reg <= (cnt_reg == 8'(STEP - 1)) ? 8'h00 : cnt_reg + 8'h01;
      if (cnt_reg == 8'(STEP - 1))
        pos_reg <= (pos_reg == 4'h8) ? 4'h0 : pos_reg + 4'h1;
    end
  end

  // four sensors decoded from the pallet position
  // order front_first, front_second, rear_first, rear_second
  always_comb begin
    case (pos_reg)
      4'h1: sens = 4'h8;
      4'h2, 4'h3: sens = 4'hc;
      4'h4: sens = 4'h6;
      4'h5, 4'h6: sens = 4'h3;
      4'h7: sens = 4'h1;
      default: sens = 4'h0;
    endcase
  end

  // two redundant channels
  // both mirror the field; a commanded fault pulls only the second low
  assign blocked = (pos_reg >= 4'h3) && (pos_reg <= 4'h5);
  assign chan_a  = ~blocked;
  assign chan_b  = ~blocked & ~chan_fault;
endmodule
`default_nettype wire

// >>> test_muting_safety_bridge.sv
// self-checking bench for the muting safety bridge
`timescale 1ns/1ps
`default_nettype none
`define CHK(got, exp) begin checks++; if ((got) !== (exp)) begin bad_count++; \
  $display("MISMATCH t=%0t got=%h exp=%h", $time, (got), (exp)); end end
module test_muting_safety_bridge
  import msb_pkg::*;
;
  // ==========================================================================
  // stimulus and observed signals
  logic          clk = 1'b0, rst_b = 1'b0, cyc = 1'b0, we = 1'b0;
  logic [7:0]    adr = 8'h00;
  logic [3:0]    sel = 4'h0;
  logic [31:0]   wdat = 32'h0, rd, dat_o;
  logic          go = 1'b0, hold = 1'b0, chan_fault = 1'b0, pause = 1'b0, ovr = 1'b0;
  logic          end_mode = 1'b0, style = 1'b0, start = 1'b0;
  logic          chan_a, chan_b, lamp, enable, ovr_on, fault, ack;
  logic [3:0]    sens;
  msb_note_type  notes;
  msb_timer_type timers;
  int            bad_count = 0, checks = 0, cycles = 0, seed = 32'hbeaebda7;
  logic [15:0]   v;
  logic [7:0]    adr_t [3] = '{ADR_MON, ADR_DROP, ADR_OVR};
  logic [15:0]   max_t [3] = '{MON_MAX, DROP_MAX, OVR_MAX};

  initial forever #5 clk = ~clk;

  msb_field_model #(.STEP(20)) field_u (.clk(clk), .rst_b(rst_b), .go(go), .hold(hold),
    .chan_fault(chan_fault), .chan_a(chan_a), .chan_b(chan_b), .sens(sens));

  // short tick keeps timed phases to a few hundred cycles
  msb_bridge #(.TICK_COUNT(4)) dut_u (.clk(clk), .rst_b(rst_b), .wb_cyc_i(cyc), .wb_stb_i(cyc),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(dat_o), .wb_ack_o(ack),
    .barrier_chan_a(chan_a), .barrier_chan_b(chan_b), .mute_sensor_front_first(sens[3]),
    .mute_sensor_front_second(sens[2]), .mute_sensor_rear_first(sens[1]),
    .mute_sensor_rear_second(sens[0]), .pause_mute_timer_in(pause), .override_button_in(ovr),
    .end_on_free_field_mode(end_mode), .override_style_select(style), .start_button_in(start),
    .mute_lamp_out(lamp), .safety_enable_out(enable), .override_active_out(ovr_on),
    .single_channel_fault(fault), .notes(notes), .timers(timers));

  // ==========================================================================
  // helpers
  // presets above the limit are clamped by the slave
  function automatic logic [15:0] clamp(input logic [15:0] x, input logic [15:0] m);
    return (x > m) ? m : x;
  endfunction

  // classic single wishbone cycle; waits for ack, only the watchdog ends it
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    cyc <= 1'b1;
    we <= w;
    adr <= a;
    sel <= 4'hf;
    wdat <= d;
    do @(posedge clk); while (ack !== 1'b1);
    rd = dat_o;
    cyc <= 1'b0;
    we <= 1'b0;
  endtask

  task automatic tally_and_finish();
    $display("checks=%0d bad_count=%0d", checks, bad_count);
    if (bad_count == 0 && checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  // watchdog: a hang counts as a mismatch
  always @(posedge clk) begin
    cycles++;
    if (cycles == 20000) begin
      bad_count++;
      tally_and_finish();
    end
  end

  // ==========================================================================
  // main sequence
  initial begin
    repeat (8) @(posedge clk);
    `CHK({lamp, enable, ovr_on, timers}, 6'h00)
    repeat (8) @(posedge clk);
    rst_b <= 1'b1;
    repeat (4) @(posedge clk);
    // presets: reset value, limits, random values, unmapped place
    wb(1'b0, ADR_MON, 32'h0);
    `CHK(rd, {16'h0, PRESET_RESET})
    for (int i = 0; i < 12; i++) begin
      v = (i < 3) ? max_t[i % 3] + 16'h1 : (i < 6) ? max_t[i % 3] : 16'($random(seed));
      wb(1'b1, adr_t[i % 3], {16'h0, v});
      wb(1'b0, adr_t[i % 3], 32'h0);
      `CHK(rd, {16'h0, clamp(v, max_t[i % 3])})
    end
    wb(1'b1, 8'h20, 32'h1234);
    wb(1'b0, 8'h20, 32'h0);
    `CHK(rd, 32'h0)
    wb(1'b1, ADR_MON, 32'h0a);
    wb(1'b1, ADR_DROP, 32'h64);
    wb(1'b1, ADR_OVR, 32'h05);
    // channel disagreement, then edge start held high before release
    chan_fault <= 1'b1;
    repeat (6) @(posedge clk);
    `CHK({fault, notes.note_barrier_fault}, 2'b11)
    chan_fault <= 1'b0;
    repeat (6) @(posedge clk);
    `CHK(fault, 1'b0)
    start <= 1'b1;
    repeat (10) @(posedge clk);
    `CHK(enable, 1'b0)
    start <= 1'b0;
    repeat (6) @(posedge clk);
    `CHK(enable, 1'b1)
    // pallet pass ended early by the free field
    end_mode <= 1'b1;
    go <= 1'b1;
    @(posedge clk);
    go <= 1'b0;
    while (lamp !== 1'b1) @(posedge clk);
    repeat (2) @(posedge clk);
    `CHK({enable, timers.monitor_timer_running, notes.note_muting_active, notes.note_single_sensor}, 4'hf)
    while (chan_a !== 1'b0) @(posedge clk);
    repeat (6) @(posedge clk);
    `CHK({lamp, enable}, 2'b11)
    while (lamp !== 1'b0) @(posedge clk);
    repeat (2) @(posedge clk);
    `CHK({chan_a, sens}, 5'h13)
    `CHK({notes.note_timeout_end, notes.note_no_new_mute, timers.monitor_timer_running}, 3'b110)
    while (sens !== 4'h0) @(posedge clk);
    // one channel drops in run: drop-out delay starts, cleared well before expiry
    // the wait also lets the pallet model return to idle so the next go is seen
    chan_fault <= 1'b1;
    repeat (12) @(posedge clk);
    `CHK({enable, timers.dropout_timer_running, fault}, 3'b111)
    chan_fault <= 1'b0;
    repeat (12) @(posedge clk);
    `CHK({enable, timers.dropout_timer_running}, 2'b10)
    // jammed pallet: pause holds the timer, then it runs out
    end_mode <= 1'b0;
    wb(1'b1, ADR_MON, 32'h01);
    go <= 1'b1;
    @(posedge clk);
    go <= 1'b0;
    while (chan_a !== 1'b0) @(posedge clk);
    hold <= 1'b1;
    pause <= 1'b1;
    repeat (600) @(posedge clk);
    `CHK({lamp, notes.note_motion_seen, notes.note_mute_paused}, 3'b100)
    pause <= 1'b0;
    while (lamp !== 1'b0) @(posedge clk);
    repeat (2) @(posedge clk);
    `CHK({enable, notes.note_timeout_end, notes.note_override_only}, 3'b011)
    // edge override runs out and must not retrigger while held
    ovr <= 1'b1;
    repeat (6) @(posedge clk);
    `CHK({ovr_on, enable, timers.override_timer_running}, 3'b111)
    while (ovr_on !== 1'b0) @(posedge clk);
    repeat (10) @(posedge clk);
    `CHK({ovr_on, enable, notes.note_override_ended}, 3'b001)
    ovr <= 1'b0;
    style <= 1'b1;
    repeat (4) @(posedge clk);
    // held override ends on early release
    ovr <= 1'b1;
    repeat (8) @(posedge clk);
    `CHK(ovr_on, 1'b1)
    ovr <= 1'b0;
    repeat (6) @(posedge clk);
    `CHK({ovr_on, enable}, 2'b00)
    hold <= 1'b0;
    while (sens !== 4'h0) @(posedge clk);
    pause <= 1'b1;
    repeat (6) @(posedge clk);
    `CHK(notes.note_mute_paused, 1'b1)
    // status: stop, timeout_end, override_ended and mute_paused notes standing
    wb(1'b0, ADR_STATUS, 32'h0);
    `CHK(rd, 32'h0000_0054)
    // auto start: free field starts without the button
    wb(1'b1, ADR_CTRL, 32'h1);
    repeat (4) @(posedge clk);
    `CHK(enable, 1'b1)
    tally_and_finish();
  end
endmodule
`default_nettype wire
